// [rtl/macsc_top.v]
/*
  MAC statistics counters: six frame counters, half flags, masks,
  interrupt and control, behind an AXI4-Lite slave.
  Assumes frame status inputs are one-cycle pulses synchronous to
  aclk, one pulse per completed frame.
*/
`timescale 1ns/100ps
`default_nettype none
`include "macsc_map.vh"

module macsc_top #(
  parameter CNT_W = 32
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        half_duplex,
  input  wire        tx_good_frame,
  input  wire        tx_one_coll_frame,
  input  wire        tx_multi_coll_frame,
  input  wire        rx_crc_err_frame,
  input  wire        rx_align_err_frame,
  input  wire        rx_good_ucast_frame,
  output wire        stat_irq
);

  localparam NCNT = 6;

  // Counter indices
  localparam I_ONE   = 0;
  localparam I_MULTI = 1;
  localparam I_GOOD  = 2;
  localparam I_CRC   = 3;
  localparam I_ALIGN = 4;
  localparam I_UCAST = 5;

  // Write channel state
  reg              awready_q;
  reg              wready_q;
  reg              bvalid_q;
  reg  [1:0]       bresp_q;
  reg              aw_held_q;
  reg              w_held_q;
  reg  [11:0]      wr_addr_q;
  reg  [31:0]      wr_data_q;
  reg  [3:0]       wr_strb_q;

  // Read channel state
  reg              arready_q;
  reg              rd_pend_q;
  reg  [11:0]      rd_addr_q;
  reg              rvalid_q;
  reg  [31:0]      rdata_q;
  reg  [1:0]       rresp_q;

  // Software registers
  reg  [31:0]      ctl_q;
  reg  [31:0]      rx_mask_q;
  reg  [31:0]      tx_mask_q;
  reg              cnt_reset_q;
  reg              preset_q;
  reg  [NCNT-1:0]  flag_q;
  reg  [NCNT-1:0]  flag_clr;
  reg              irq_q;

  reg  [31:0]      wr_old;
  reg              wr_known;
  reg  [31:0]      rd_mux;
  reg              rd_known;

  wire             wr_go;
  wire [31:0]      wr_merged;
  wire [NCNT-1:0]  cnt_inc;
  wire [NCNT-1:0]  cnt_rd_clr;
  wire [NCNT-1:0]  half_evt;
  wire [NCNT-1:0]  mask_vec;
  wire [NCNT*CNT_W-1:0] cnt_flat;
  wire [CNT_W-1:0] preset_val;
  wire [11:0]      rd_word;
  wire [11:0]      wr_word;

  function [11:0] cnt_ofs;
    input integer idx;
    begin
      case (idx)
        I_ONE:   cnt_ofs = `MACSC_OFS_ONE_COLL;
        I_MULTI: cnt_ofs = `MACSC_OFS_MULTI_COLL;
        I_GOOD:  cnt_ofs = `MACSC_OFS_TX_GOOD;
        I_CRC:   cnt_ofs = `MACSC_OFS_CRC_ERR;
        I_ALIGN: cnt_ofs = `MACSC_OFS_ALIGN_ERR;
        default: cnt_ofs = `MACSC_OFS_UCAST;
      endcase
    end
  endfunction

  assign rd_word = {rd_addr_q[11:2], 2'b00};
  assign wr_word = {wr_addr_q[11:2], 2'b00};

  // collision counts only in half duplex
  assign cnt_inc[I_ONE]   = tx_one_coll_frame & half_duplex;
  assign cnt_inc[I_MULTI] = tx_multi_coll_frame & half_duplex;
  assign cnt_inc[I_GOOD]  = tx_good_frame;
  assign cnt_inc[I_CRC]   = rx_crc_err_frame;
  assign cnt_inc[I_ALIGN] = rx_align_err_frame;
  assign cnt_inc[I_UCAST] = rx_good_ucast_frame;

  assign preset_val = ctl_q[`MACSC_CTL_PRESET_LVL] ? `MACSC_PRESET_FULL : `MACSC_PRESET_HALF;

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
      // clear after the read that returns it
      assign cnt_rd_clr[gi] = rd_pend_q & ctl_q[`MACSC_CTL_CLR_READ] & (rd_word == cnt_ofs(gi));

      macsc_counter #(
        .CNT_W (CNT_W)
      ) u_cnt (
        .clk        (aclk),
        .rst_n      (aresetn),
        .inc        (cnt_inc[gi]),
        .cnt_reset  (cnt_reset_q),
        .preset     (preset_q),
        .preset_val (preset_val),
        .rd_clr     (cnt_rd_clr[gi]),
        .freeze     (ctl_q[`MACSC_CTL_FREEZE]),
        .stop_roll  (ctl_q[`MACSC_CTL_STOP_ROLL]),
        .count      (cnt_flat[gi*CNT_W +: CNT_W]),
        .half_evt   (half_evt[gi])
      );
    end
  endgenerate

  // AXI write channel: address and data taken in either order
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MACSC_RESP_OKAY;
      wr_addr_q <= 12'h000;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_q) begin
        wready_q  <= 1'b0;
        w_held_q  <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? `MACSC_RESP_OKAY : `MACSC_RESP_SLVERR;
      end
      if (bvalid_q & s_axi_bready) begin
        bvalid_q  <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Current value of the write target and whether it exists
  always @* begin
    wr_old   = 32'h00000000;
    wr_known = 1'b1;
    case (wr_word)
      `MACSC_OFS_CTL:      wr_old = ctl_q;
      `MACSC_OFS_RX_MASKS: wr_old = rx_mask_q;
      `MACSC_OFS_TX_MASKS: wr_old = tx_mask_q;
      `MACSC_OFS_RX_FLAGS,
      `MACSC_OFS_TX_FLAGS,
      `MACSC_OFS_ONE_COLL,
      `MACSC_OFS_MULTI_COLL,
      `MACSC_OFS_TX_GOOD,
      `MACSC_OFS_CRC_ERR,
      `MACSC_OFS_ALIGN_ERR,
      `MACSC_OFS_UCAST:    wr_old = 32'h00000000;
      default:             wr_known = 1'b0;
    endcase
  end

  macsc_byte_merge #(
    .WIDTH (32)
  ) u_merge (
    .old_val (wr_old),
    .new_val (wr_data_q),
    .strb    (wr_strb_q),
    .merged  (wr_merged)
  );

  // Writable registers; counters and flags ignore writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q       <= `MACSC_CTL_RST;
      rx_mask_q   <= `MACSC_MASK_RST;
      tx_mask_q   <= `MACSC_MASK_RST;
      cnt_reset_q <= 1'b0;
      preset_q    <= 1'b0;
    end else begin
      cnt_reset_q <= 1'b0;
      preset_q    <= 1'b0;
      if (wr_go) begin
        case (wr_word)
          `MACSC_OFS_CTL: begin
            // Reset and preset bits act once and read back as zero
            ctl_q       <= wr_merged & `MACSC_CTL_KEEP;
            cnt_reset_q <= wr_merged[`MACSC_CTL_RESET];
            preset_q    <= wr_merged[`MACSC_CTL_PRESET];
          end
          `MACSC_OFS_RX_MASKS: rx_mask_q <= wr_merged & `MACSC_RX_MASK_BITS;
          `MACSC_OFS_TX_MASKS: tx_mask_q <= wr_merged & `MACSC_TX_MASK_BITS;
          default: ;
        endcase
      end
    end
  end

  // reading a flag register clears its flags
  always @* begin
    flag_clr = {NCNT{1'b0}};
    if (rd_pend_q && rd_word == `MACSC_OFS_RX_FLAGS) begin
      flag_clr[I_CRC]   = 1'b1;
      flag_clr[I_ALIGN] = 1'b1;
      flag_clr[I_UCAST] = 1'b1;
    end
    if (rd_pend_q && rd_word == `MACSC_OFS_TX_FLAGS) begin
      flag_clr[I_ONE]   = 1'b1;
      flag_clr[I_MULTI] = 1'b1;
      flag_clr[I_GOOD]  = 1'b1;
    end
  end

  assign mask_vec = {rx_mask_q[`MACSC_RX_UCAST_BIT], rx_mask_q[`MACSC_RX_ALIGN_BIT],
                     rx_mask_q[`MACSC_RX_CRC_BIT], tx_mask_q[`MACSC_TX_GOOD_BIT],
                     tx_mask_q[`MACSC_TX_MULTI_BIT], tx_mask_q[`MACSC_TX_ONE_BIT]};

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= {NCNT{1'b0}};
      irq_q  <= 1'b0;
    end else begin
      // a crossing in the clearing cycle still sets the flag
      flag_q <= (flag_q & ~flag_clr) | half_evt;
      // any unmasked set flag drives the interrupt
      irq_q  <= |(flag_q & ~mask_vec);
    end
  end

  // Read data selection
  always @* begin
    rd_mux   = 32'h00000000;
    rd_known = 1'b1;
    case (rd_word)
      `MACSC_OFS_CTL:        rd_mux = ctl_q;
      `MACSC_OFS_RX_FLAGS: begin
        rd_mux[`MACSC_RX_UCAST_BIT] = flag_q[I_UCAST];
        rd_mux[`MACSC_RX_ALIGN_BIT] = flag_q[I_ALIGN];
        rd_mux[`MACSC_RX_CRC_BIT]   = flag_q[I_CRC];
      end
      `MACSC_OFS_TX_FLAGS: begin
        rd_mux[`MACSC_TX_GOOD_BIT]  = flag_q[I_GOOD];
        rd_mux[`MACSC_TX_MULTI_BIT] = flag_q[I_MULTI];
        rd_mux[`MACSC_TX_ONE_BIT]   = flag_q[I_ONE];
      end
      `MACSC_OFS_RX_MASKS:   rd_mux = rx_mask_q;
      `MACSC_OFS_TX_MASKS:   rd_mux = tx_mask_q;
      `MACSC_OFS_ONE_COLL:   rd_mux = cnt_flat[I_ONE*CNT_W +: CNT_W];
      `MACSC_OFS_MULTI_COLL: rd_mux = cnt_flat[I_MULTI*CNT_W +: CNT_W];
      `MACSC_OFS_TX_GOOD:    rd_mux = cnt_flat[I_GOOD*CNT_W +: CNT_W];
      `MACSC_OFS_CRC_ERR:    rd_mux = cnt_flat[I_CRC*CNT_W +: CNT_W];
      `MACSC_OFS_ALIGN_ERR:  rd_mux = cnt_flat[I_ALIGN*CNT_W +: CNT_W];
      `MACSC_OFS_UCAST:      rd_mux = cnt_flat[I_UCAST*CNT_W +: CNT_W];
      default:               rd_known = 1'b0;
    endcase
  end

  // AXI read channel; data latched in the same cycle as the read clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 12'h000;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `MACSC_RESP_OKAY;
    end else begin
      rd_pend_q <= 1'b0;
      if (s_axi_arvalid & arready_q) begin
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
        rd_addr_q <= s_axi_araddr;
      end
      if (rd_pend_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_known ? `MACSC_RESP_OKAY : `MACSC_RESP_SLVERR;
      end
      if (rvalid_q & s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign stat_irq      = irq_q;

endmodule // macsc_top

`default_nettype wire

// [rtl/macsc_map.vh]
/*
  Register map, field positions, reset and preset values of the
  MAC statistics counter block.
  Included by the block's design files; holds definitions only.
*/
`ifndef MACSC_MAP_VH
`define MACSC_MAP_VH

// Byte offsets of the registers
`define MACSC_OFS_CTL        12'h100
`define MACSC_OFS_RX_FLAGS   12'h104
`define MACSC_OFS_TX_FLAGS   12'h108
`define MACSC_OFS_RX_MASKS   12'h10c
`define MACSC_OFS_TX_MASKS   12'h110
`define MACSC_OFS_ONE_COLL   12'h14c
`define MACSC_OFS_MULTI_COLL 12'h150
`define MACSC_OFS_TX_GOOD    12'h168
`define MACSC_OFS_CRC_ERR    12'h194
`define MACSC_OFS_ALIGN_ERR  12'h198
`define MACSC_OFS_UCAST      12'h1c4

// Control register fields
`define MACSC_CTL_RESET      0
`define MACSC_CTL_STOP_ROLL  1
`define MACSC_CTL_CLR_READ   2
`define MACSC_CTL_FREEZE     3
`define MACSC_CTL_PRESET     4
`define MACSC_CTL_PRESET_LVL 5
`define MACSC_CTL_KEEP       32'h0000002e

// Half flag and mask bit positions
`define MACSC_RX_UCAST_BIT   17
`define MACSC_RX_ALIGN_BIT   6
`define MACSC_RX_CRC_BIT     5
`define MACSC_TX_GOOD_BIT    21
`define MACSC_TX_MULTI_BIT   15
`define MACSC_TX_ONE_BIT     14
`define MACSC_RX_MASK_BITS   32'h00020060
`define MACSC_TX_MASK_BITS   32'h0020c000

// Reset and preset values
`define MACSC_CTL_RST        32'h00000000
`define MACSC_MASK_RST       32'h00000000
`define MACSC_PRESET_FULL    32'hfffffff0
`define MACSC_PRESET_HALF    32'h7ffffff0

// Bus responses
`define MACSC_RESP_OKAY      2'b00
`define MACSC_RESP_SLVERR    2'b10

`endif

// [rtl/macsc_counter.v]
/*
  One statistics counter with stop-rollover, freeze, read-clear,
  preset and a half-maximum crossing pulse.
  Assumes one clock; all controls are one-cycle pulses or levels
  synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none

module macsc_counter #(
  parameter CNT_W = 32
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             inc,
  input  wire             cnt_reset,
  input  wire             preset,
  input  wire [CNT_W-1:0] preset_val,
  input  wire             rd_clr,
  input  wire             freeze,
  input  wire             stop_roll,
  output wire [CNT_W-1:0] count,
  output wire             half_evt
);

  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  wire             step;

  // Frozen counters ignore frames but still clear on read
  assign step = inc & ~freeze;

  always @* begin
    cnt_d = cnt_q;
    if (cnt_reset) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (preset) begin
      cnt_d = preset_val;
    end else if (rd_clr) begin
      // Frame in the read cycle is kept, not lost
      cnt_d = step ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
    end else if (step) begin
      if (~(&cnt_q) | ~stop_roll) begin
        cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count    = cnt_q;
  assign half_evt = ~cnt_q[CNT_W-1] & cnt_d[CNT_W-1];

endmodule // macsc_counter

`default_nettype wire

// [rtl/macsc_byte_merge.v]
/*
  Merges write data into an old register value by byte strobes.
  Pure combinational; assumes WIDTH is a multiple of eight.
*/
`timescale 1ns/100ps
`default_nettype none

module macsc_byte_merge #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0]   old_val,
  input  wire [WIDTH-1:0]   new_val,
  input  wire [WIDTH/8-1:0] strb,
  output wire [WIDTH-1:0]   merged
);

  genvar b;
  generate
    for (b = 0; b < WIDTH/8; b = b + 1) begin : g_lane
      assign merged[8*b+7:8*b] = strb[b] ? new_val[8*b+7:8*b] : old_val[8*b+7:8*b];
    end
  endgenerate

endmodule // macsc_byte_merge

`default_nettype wire

// [dv/macsc_top_sva.sv]
/*
  Checker for the statistics counter block: bus handshakes and the
  interrupt's causes, seen at the top module's ports only.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module macsc_top_chk #(
  parameter CNT_W = 32
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_good_frame,
  input wire logic        tx_one_coll_frame,
  input wire logic        tx_multi_coll_frame,
  input wire logic        rx_crc_err_frame,
  input wire logic        rx_align_err_frame,
  input wire logic        rx_good_ucast_frame,
  input wire logic        stat_irq
);
  wire logic any_evt = tx_good_frame | tx_one_coll_frame | tx_multi_coll_frame
                     | rx_crc_err_frame | rx_align_err_frame | rx_good_ucast_frame;
  wire logic ar_hs = s_axi_arvalid & s_axi_arready;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Only a frame, a preset or an unmask can raise it
  irq_rise_a:
    assert property ($rose(stat_irq) |-> $past(any_evt) || $past(any_evt, 2) || $past(s_axi_bvalid)
                     || $past(s_axi_bvalid, 2)) else $error("stat_irq rose without cause");
  irq_fall_a:
    assert property ($fell(stat_irq) |-> $past(ar_hs, 2) || $past(ar_hs, 3) || $past(ar_hs, 4)
                     || $past(s_axi_bvalid)) else $error("stat_irq fell without read or write");
  irq_reset_a:
    assert property ($rose(aresetn) |-> !stat_irq) else $error("stat_irq high after reset");
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
  rd_resp_a:
    assert property (ar_hs |-> ##[1:2] s_axi_rvalid) else $error("read response late");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while stalled");
  aw_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");

  cover property ($rose(stat_irq));
  cover property ($fell(stat_irq));
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule // macsc_top_chk

bind macsc_top macsc_top_chk #(.CNT_W(CNT_W)) i_macsc_top_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .tx_good_frame, .tx_one_coll_frame, .tx_multi_coll_frame, .rx_crc_err_frame,
  .rx_align_err_frame, .rx_good_ucast_frame, .stat_irq
);

`default_nettype wire

// [dv/macsc_frame_src.sv]
/*
  Model of the MAC frame status logic: one-cycle pulse per finished
  frame on each status line, and the duplex level.
  Assumes the caller owns the clock and calls one task at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module macsc_frame_src (
  input  wire logic       aclk,
  output var  logic       half_duplex,
  output var  logic [5:0] frame_evt
);
  initial begin
    half_duplex = 1'b0;
    frame_evt   = 6'h00;
  end

  // Gap of zero gives back-to-back frames, the hardest case
  task automatic send(input logic h, input logic [5:0] m, input int n, input int gap);
    @(posedge aclk);
    half_duplex <= h;
    for (int i = 0; i < n; i++) begin
      frame_evt <= m;
      if (gap > 0) begin
        @(posedge aclk);
        frame_evt <= 6'h00;
        repeat (gap - 1) @(posedge aclk);
      end
      @(posedge aclk);
    end
    frame_evt <= 6'h00;
    repeat (2) @(posedge aclk);
  endtask
endmodule // macsc_frame_src

`default_nettype wire

// [dv/macsc_top_test.sv]
/*
  Self-checking bench of the statistics counter block.
  Assumes the register map header is on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "macsc_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end

module macsc_top_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, stat_irq, hd;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  evt;
  int          failures, checks;
  localparam logic [11:0] cnt_ofs [6] = '{`MACSC_OFS_TX_GOOD, `MACSC_OFS_ONE_COLL, `MACSC_OFS_MULTI_COLL,
                                          `MACSC_OFS_CRC_ERR, `MACSC_OFS_ALIGN_ERR, `MACSC_OFS_UCAST};

  macsc_top i_macsc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .half_duplex(hd), .tx_good_frame(evt[0]), .tx_one_coll_frame(evt[1]), .tx_multi_coll_frame(evt[2]),
    .rx_crc_err_frame(evt[3]), .rx_align_err_frame(evt[4]), .rx_good_ucast_frame(evt[5]),
    .stat_irq(stat_irq)
  );

  macsc_frame_src i_macsc_frame_src (.aclk(aclk), .half_duplex(hd), .frame_evt(evt));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge aclk);
    if (!bready) begin
      bready <= 1'b1;
      @(posedge aclk);
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    if (!rready) begin
      rready <= 1'b1;
      @(posedge aclk);
    end
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_regs;
    slow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(cnt_ofs[i]);
      `CHK(rv, 32'h00000000)
    end
    rd(`MACSC_OFS_RX_MASKS);
    `CHK(rv, 32'h00000000)
    `CHK(resp, `MACSC_RESP_OKAY)
    rd(12'h1f0);
    `CHK(resp, `MACSC_RESP_SLVERR)
    wr(12'h1f0, 32'hffffffff, 4'hf);
    `CHK(resp, `MACSC_RESP_SLVERR)
    wr(`MACSC_OFS_RX_MASKS, 32'hffffffff, 4'b0100);
    `CHK(resp, `MACSC_RESP_OKAY)
    rd(`MACSC_OFS_RX_MASKS);
    `CHK(rv, 32'h00020000)
    wr(`MACSC_OFS_RX_MASKS, 32'hffffffff, 4'b0001);
    rd(`MACSC_OFS_RX_MASKS);
    `CHK(rv, 32'h00020060)
    wr(`MACSC_OFS_TX_MASKS, 32'hffffffff, 4'b0010);
    rd(`MACSC_OFS_TX_MASKS);
    `CHK(rv, 32'h0000c000)
    wr(`MACSC_OFS_TX_MASKS, 32'hffffffff, 4'b1100);
    rd(`MACSC_OFS_TX_MASKS);
    `CHK(rv, 32'h0020c000)
    wr(`MACSC_OFS_TX_GOOD, 32'hffffffff, 4'hf);
    `CHK(resp, `MACSC_RESP_OKAY)
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000000)
    slow = 1'b0;
  endtask

  // Collision counts must ignore frames sent in full duplex
  task automatic t_count;
    i_macsc_frame_src.send(1'b0, 6'h3f, 1, 0);
    i_macsc_frame_src.send(1'b1, 6'h3f, 2, 1);
    for (int i = 0; i < 6; i++) begin
      rd(cnt_ofs[i]);
      `CHK(rv, (i == 1 || i == 2) ? 32'h00000002 : 32'h00000003)
    end
  endtask

  task automatic t_half;
    wr(`MACSC_OFS_CTL, 32'h00000010, 4'hf);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h7ffffff0)
    i_macsc_frame_src.send(1'b1, 6'h3f, 16, 1);
    `CHK(stat_irq, 1'b0)
    rd(`MACSC_OFS_UCAST);
    `CHK(rv, 32'h80000000)
    wr(`MACSC_OFS_RX_MASKS, 32'h00020040, 4'hf);
    repeat (2) @(posedge aclk);
    `CHK(stat_irq, 1'b1)
    rd(`MACSC_OFS_RX_FLAGS);
    `CHK(rv, 32'h00020060)
    repeat (3) @(posedge aclk);
    `CHK(stat_irq, 1'b0)
    rd(`MACSC_OFS_RX_FLAGS);
    `CHK(rv, 32'h00000000)
    wr(`MACSC_OFS_TX_MASKS, 32'h0000c000, 4'hf);
    repeat (2) @(posedge aclk);
    `CHK(stat_irq, 1'b1)
    rd(`MACSC_OFS_TX_FLAGS);
    `CHK(rv, 32'h0020c000)
    repeat (3) @(posedge aclk);
    `CHK(stat_irq, 1'b0)
  endtask

  task automatic t_ctl;
    wr(`MACSC_OFS_CTL, 32'h00000032, 4'hf);
    // Preset bit acts once and reads back as zero
    rd(`MACSC_OFS_CTL);
    `CHK(rv, 32'h00000022)
    i_macsc_frame_src.send(1'b1, 6'h01, 20, 0);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'hffffffff)
    wr(`MACSC_OFS_CTL, 32'h00000030, 4'hf);
    i_macsc_frame_src.send(1'b1, 6'h01, 20, 0);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000004)
    wr(`MACSC_OFS_CTL, 32'h00000004, 4'hf);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000004)
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000000)
    wr(`MACSC_OFS_CTL, 32'h00000000, 4'hf);
    i_macsc_frame_src.send(1'b1, 6'h01, 2, 0);
    wr(`MACSC_OFS_CTL, 32'h00000008, 4'hf);
    i_macsc_frame_src.send(1'b1, 6'h01, 3, 0);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000002)
    wr(`MACSC_OFS_CTL, 32'h0000000c, 4'hf);
    rd(`MACSC_OFS_TX_GOOD);
    rd(`MACSC_OFS_TX_GOOD);
    `CHK(rv, 32'h00000000)
    // Counter reset bit clears every counter and self-clears
    wr(`MACSC_OFS_CTL, 32'h00000001, 4'hf);
    rd(`MACSC_OFS_CTL);
    `CHK(rv, 32'h00000000)
    rd(`MACSC_OFS_UCAST);
    `CHK(rv, 32'h00000000)
  endtask

  task automatic wrap_up;
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    wrap_up;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_count;
    t_half;
    t_ctl;
    wrap_up;
  end
endmodule // macsc_top_test

`default_nettype wire
